// [logic/dmr_pkg.sv]
// Constants and types for the mode register bank, addresses 17h to 28h.
// Assumes the command decoder and register bank share these encodings.
package dmr_pkg;
  localparam int MA_W = 6;
  localparam int OP_W = 8;
  localparam int MPC_W = 7;
  localparam int BANK_W = 3;
  localparam int NUM_BANKS = 8;
  localparam int CAL_W = 16;
  localparam int DQ_W = 16;
  localparam int MIL_W = 2;
  localparam int TMR_W = 13;
  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [MA_W-1:0] MA_FIRST = 6'h17;
  localparam logic [MA_W-1:0] MA_STROBE_RUNTIME = 6'h17;
  localparam logic [MA_W-1:0] MA_ACT_TRR = 6'h18;
  localparam logic [MA_W-1:0] MA_REPAIR = 6'h19;
  localparam logic [MA_W-1:0] MA_RSVD_A_LO = 6'h1A;
  localparam logic [MA_W-1:0] MA_RSVD_A_HI = 6'h1D;
  localparam logic [MA_W-1:0] MA_TEST = 6'h1E;
  localparam logic [MA_W-1:0] MA_RSVD_B = 6'h1F;
  localparam logic [MA_W-1:0] MA_CAL_A = 6'h20;
  localparam logic [MA_W-1:0] MA_UNUSED_LO = 6'h21;
  localparam logic [MA_W-1:0] MA_UNUSED_HI = 6'h26;
  localparam logic [MA_W-1:0] MA_CAL_B = 6'h28;
  localparam logic [MA_W-1:0] MA_LAST = 6'h28;
  // ---------------------------------------------------------------
  // Reset values and fields
  // ---------------------------------------------------------------
  localparam logic [OP_W-1:0] RST_RUNTIME = 8'h00;
  localparam logic [OP_W-1:0] RST_CAL_A = 8'h5A;
  localparam logic [OP_W-1:0] RST_CAL_B = 8'h3C;
  localparam logic RST_TRR_EN = 1'b0;
  localparam logic [BANK_W-1:0] RST_TRR_BANK = 3'h0;
  localparam int TRR_EN_BIT = 7;
  localparam int TRR_BANK_LSB = 4;
  localparam int ACT_UNLIM_BIT = 3;
  localparam int ACT_CODE_LSB = 0;
  localparam int ACT_CODE_W = 3;
  localparam logic [ACT_CODE_W-1:0] ACT_CODE_RSVD = 3'h7;
  // ---------------------------------------------------------------
  // Command encodings, first tick CA[4:0]
  // ---------------------------------------------------------------
  localparam logic [4:0] CA_MRW1 = 5'h06;
  localparam logic [4:0] CA_MRW2 = 5'h16;
  localparam logic [4:0] CA_MRR1 = 5'h0E;
  localparam logic [4:0] CA_MPC = 5'h00;
  localparam logic [MPC_W-1:0] MPC_OP_STOP_OSC = 7'h4D;
  localparam logic [MPC_W-1:0] MPC_OP_READ_CAL = 7'h43;
  localparam logic [MPC_W-1:0] MPC_OP_START_OSC = 7'h4B;
  // ---------------------------------------------------------------
  // Timer and serializer counts
  // ---------------------------------------------------------------
  localparam logic [1:0] RT_MODE_SHORT = 2'h0;
  localparam logic [1:0] RT_MODE_A = 2'h1;
  localparam logic [1:0] RT_MODE_B = 2'h2;
  localparam int RT_UNIT_SHIFT = 4;
  localparam logic [TMR_W-1:0] RT_LONG_A = 13'h0800;
  localparam logic [TMR_W-1:0] RT_LONG_B = 13'h1000;
  localparam logic [4:0] CAL_BEATS = 5'h10;
  typedef enum logic [1:0] {DMR_DC_IDLE = 2'h0, DMR_DC_SECOND = 2'h1} dmr_dc_state_t;
endpackage

// [logic/dmr_cmd_if.sv]
// Decoded command strobes from the CA decoder to the register bank.
// Assumes one clock domain; strobes are one-cycle pulses.
`timescale 1ns/1ps
interface dmr_cmd_if;
  logic mrw_stb;
  logic [5:0] mrw_addr;
  logic [7:0] mrw_data;
  logic mrr_stb;
  logic [5:0] mrr_addr;
  logic mpc_stb;
  logic [6:0] mpc_op;
  modport dec (output mrw_stb, mrw_addr, mrw_data, mrr_stb, mrr_addr, mpc_stb, mpc_op);
  modport bank (input mrw_stb, mrw_addr, mrw_data, mrr_stb, mrr_addr, mpc_stb, mpc_op);
endinterface

// [logic/dmr_ca_decode.sv]
// Two-tick command capture on the six-lane CA bus.
// Assumes CA and cs are synchronous to clock and qualified by clk_en.
`timescale 1ns/1ps
module dmr_ca_decode
  import dmr_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic cs,
  input wire logic [dmr_pkg::MA_W-1:0] ca,
  dmr_cmd_if.dec cmd
);
  dmr_dc_state_t state_q;
  logic [MA_W-1:0] first_q;
  logic mrw_pend_q;
  logic op7_q;

  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      state_q <= DMR_DC_IDLE;
      first_q <= '0;
    end
    else if (clk_en)
    begin
      case (state_q)
        DMR_DC_IDLE:
          if (cs)
          begin
            state_q <= DMR_DC_SECOND;
            first_q <= ca;
          end
        DMR_DC_SECOND: state_q <= DMR_DC_IDLE;
        default: state_q <= DMR_DC_IDLE;
      endcase
    end

  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      cmd.mrw_stb <= 1'b0;
      cmd.mrw_addr <= '0;
      cmd.mrw_data <= '0;
      cmd.mrr_stb <= 1'b0;
      cmd.mrr_addr <= '0;
      cmd.mpc_stb <= 1'b0;
      cmd.mpc_op <= '0;
      mrw_pend_q <= 1'b0;
      op7_q <= 1'b0;
    end
    else if (clk_en)
    begin
      cmd.mrw_stb <= 1'b0;
      cmd.mrr_stb <= 1'b0;
      cmd.mpc_stb <= 1'b0;
      if (state_q == DMR_DC_SECOND)
      begin
        case (first_q[4:0])
          CA_MRW1:
          begin
            mrw_pend_q <= 1'b1;
            cmd.mrw_addr <= ca;
            op7_q <= first_q[5];
          end
          CA_MRW2:
            if (mrw_pend_q)
            begin
              mrw_pend_q <= 1'b0;
              cmd.mrw_stb <= 1'b1;
              cmd.mrw_data <= {op7_q, first_q[5], ca};
            end
          CA_MRR1:
          begin
            cmd.mrr_stb <= 1'b1;
            cmd.mrr_addr <= ca;
          end
          CA_MPC:
          begin
            cmd.mpc_stb <= 1'b1;
            cmd.mpc_op <= {first_q[5], ca};
          end
          // An unrecognised command breaks a half-written pair; MRR and MPC leave it pending
          default: mrw_pend_q <= 1'b0;
        endcase
      end
    end
endmodule

// [logic/dmr_strobe_timer.sv]
// Strobe interval timer with run-time auto stop.
// Assumes start and stop_req are one-cycle pulses from the bank.
`timescale 1ns/1ps
module dmr_strobe_timer
  import dmr_pkg::*;
#(
  parameter int CNT_W = dmr_pkg::TMR_W
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic start,
  input wire logic stop_req,
  input wire logic [dmr_pkg::OP_W-1:0] runtime,
  output logic running_q
);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] limit;
  logic auto_stop;

  always_comb
  begin
    limit = '0;
    auto_stop = 1'b0;
    case (runtime[7:6])
      RT_MODE_SHORT:
      begin
        limit = CNT_W'(runtime[5:0]) << RT_UNIT_SHIFT;
        auto_stop = (runtime[5:0] != '0);
      end
      RT_MODE_A:
      begin
        limit = CNT_W'(RT_LONG_A);
        auto_stop = 1'b1;
      end
      RT_MODE_B:
      begin
        limit = CNT_W'(RT_LONG_B);
        auto_stop = 1'b1;
      end
      // Upper bits 11 are undefined: no auto stop, stop command ignored
      default: auto_stop = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      running_q <= 1'b0;
      cnt_q <= '0;
    end
    else if (clk_en)
    begin
      if (start)
      begin
        running_q <= 1'b1;
        cnt_q <= '0;
      end
      else if (running_q)
      begin
        cnt_q <= cnt_q + CNT_ONE;
        // Stop command only honoured with runtime zero
        if (stop_req && runtime == RST_RUNTIME)
          running_q <= 1'b0;
        else if (auto_stop && (cnt_q + CNT_ONE) == limit)
          running_q <= 1'b0;
      end
    end

  property p_auto_stop_16;
    @(posedge clock) disable iff (!reset_n || !clk_en)
    start && runtime == 8'h01 && !stop_req |=>
      running_q [*8] ##1 running_q [*8] ##1 !running_q;
  endproperty
  a_auto_stop_16: assert property (p_auto_stop_16) else $error("auto stop not at 16");
endmodule

// [logic/dmr_mode_regs.sv]
// Mode register bank 17h..28h with timer and calibration output.
// Assumes a single clock; the invert registers and read inversion
// enable come from neighbouring mode registers as plain inputs.
`timescale 1ns/1ps
// Operation
// - Runtime register write-only, resets zero, disables stop
// - Value N stops timer at N*16 clocks
// - Upper bits 01/10 stop at 2048/4096
// - Stop command halts timer when runtime zero
// - Activate count field reports limit code, reserved code 7 as zero
// - Unlimited bit set forces count field zero
// - Row refresh enable and bank are writable
// - Repair flags read one bit per bank
// - Test register writes are ignored
// - Pattern A resets 5Ah, writable, not readable
// - Read calibration sends pattern A then B
// - Patterns serial, LSB first, all lanes
// - Data lanes invertible, mask lanes never
// - Mask lanes idle when read inversion off
// - No bus inversion during calibration output
// - Pattern B resets 3Ch, writable
// - Upper invert bit inverts its upper lane
// - Commands captured over two clock edges
module dmr_mode_regs
  import dmr_pkg::*;
#(
  parameter int BANKS = dmr_pkg::NUM_BANKS
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic cs,
  input wire logic [dmr_pkg::MA_W-1:0] ca,
  input wire logic [dmr_pkg::ACT_CODE_W-1:0] activate_limit_code,
  input wire logic activate_unlimited,
  input wire logic [BANKS-1:0] repair_available,
  input wire logic [dmr_pkg::OP_W-1:0] lower_invert_register,
  input wire logic [dmr_pkg::OP_W-1:0] upper_invert_register,
  input wire logic read_bus_inversion_en,
  output logic rd_valid_q,
  output logic [dmr_pkg::OP_W-1:0] rd_data_q,
  output logic target_row_refresh_en_q,
  output logic [dmr_pkg::BANK_W-1:0] target_row_refresh_bank_q,
  output logic strobe_timer_running_q,
  output logic [dmr_pkg::DQ_W-1:0] dq_q,
  output logic dq_oe_q,
  output logic [dmr_pkg::MIL_W-1:0] mask_invert_lane_q,
  output logic mask_invert_lane_oe_q
);
  import dmr_pkg::*;

  localparam logic [4:0] BEAT_ONE = 5'h01;

  // ---------------------------------------------------------------
  // Command capture
  // ---------------------------------------------------------------
  dmr_cmd_if cmd_bus ();

  dmr_ca_decode u_decode (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .cs(cs),
    .ca(ca),
    .cmd(cmd_bus)
  );

  logic [OP_W-1:0] runtime_q;
  logic [OP_W-1:0] cal_a_q;
  logic [OP_W-1:0] cal_b_q;
  logic [CAL_W-1:0] cal_shift_q;
  logic [4:0] cal_beats_q;
  logic cal_busy;
  logic wr_runtime;
  logic wr_act_trr;
  logic wr_cal_a;
  logic wr_cal_b;
  logic rd_hit;
  logic mpc_start;
  logic mpc_stop;
  logic mpc_read_cal;
  logic [OP_W-1:0] act_read;
  logic [DQ_W-1:0] lane_invert;
  logic [DQ_W-1:0] dq_d;

  assign wr_runtime = cmd_bus.mrw_stb && cmd_bus.mrw_addr == MA_STROBE_RUNTIME;
  assign wr_act_trr = cmd_bus.mrw_stb && cmd_bus.mrw_addr == MA_ACT_TRR;
  assign wr_cal_a = cmd_bus.mrw_stb && cmd_bus.mrw_addr == MA_CAL_A;
  assign wr_cal_b = cmd_bus.mrw_stb && cmd_bus.mrw_addr == MA_CAL_B;
  assign rd_hit = cmd_bus.mrr_stb && cmd_bus.mrr_addr >= MA_FIRST
    && cmd_bus.mrr_addr <= MA_LAST;
  assign mpc_start = cmd_bus.mpc_stb && cmd_bus.mpc_op == MPC_OP_START_OSC;
  assign mpc_stop = cmd_bus.mpc_stb && cmd_bus.mpc_op == MPC_OP_STOP_OSC;
  assign mpc_read_cal = cmd_bus.mpc_stb && cmd_bus.mpc_op == MPC_OP_READ_CAL;
  assign cal_busy = cal_beats_q != '0;

  // ---------------------------------------------------------------
  // Writable registers
  // ---------------------------------------------------------------
  // Writes to the test and reserved addresses match nothing here
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      runtime_q <= RST_RUNTIME;
      target_row_refresh_en_q <= RST_TRR_EN;
      target_row_refresh_bank_q <= RST_TRR_BANK;
      cal_a_q <= RST_CAL_A;
      cal_b_q <= RST_CAL_B;
    end
    else if (clk_en)
    begin
      if (wr_runtime)
        runtime_q <= cmd_bus.mrw_data;
      if (wr_act_trr)
      begin
        target_row_refresh_en_q <= cmd_bus.mrw_data[TRR_EN_BIT];
        target_row_refresh_bank_q <= cmd_bus.mrw_data[TRR_BANK_LSB +: BANK_W];
      end
      if (wr_cal_a)
        cal_a_q <= cmd_bus.mrw_data;
      if (wr_cal_b)
        cal_b_q <= cmd_bus.mrw_data;
    end

  // ---------------------------------------------------------------
  // Strobe interval timer
  // ---------------------------------------------------------------
  dmr_strobe_timer #(
    .CNT_W(TMR_W)
  ) u_timer (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .start(mpc_start),
    .stop_req(mpc_stop),
    .runtime(runtime_q),
    .running_q(strobe_timer_running_q)
  );

  // ---------------------------------------------------------------
  // Mode register read
  // ---------------------------------------------------------------
  // Reserved codes are never reported; they read as zero
  always_comb
  begin
    act_read = '0;
    act_read[ACT_UNLIM_BIT] = activate_unlimited;
    if (!activate_unlimited && activate_limit_code != ACT_CODE_RSVD)
      act_read[ACT_CODE_LSB +: ACT_CODE_W] = activate_limit_code;
  end

  // Write-only, test, reserved and unused locations all read zero
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
    end
    else if (clk_en)
    begin
      rd_valid_q <= rd_hit;
      if (rd_hit)
      begin
        case (cmd_bus.mrr_addr)
          MA_ACT_TRR: rd_data_q <= act_read;
          MA_REPAIR: rd_data_q <= OP_W'(repair_available);
          default: rd_data_q <= '0;
        endcase
      end
    end

  // ---------------------------------------------------------------
  // Read calibration serializer
  // ---------------------------------------------------------------
  // A new request during a burst is dropped, not queued
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      cal_shift_q <= '0;
      cal_beats_q <= '0;
    end
    else if (clk_en)
    begin
      if (mpc_read_cal && !cal_busy)
      begin
        cal_shift_q <= {cal_b_q, cal_a_q};
        cal_beats_q <= CAL_BEATS;
      end
      else if (cal_busy)
      begin
        cal_shift_q <= cal_shift_q >> 1;
        cal_beats_q <= cal_beats_q - BEAT_ONE;
      end
    end

  assign lane_invert = {upper_invert_register, lower_invert_register};

  genvar lane;
  generate
    for (lane = 0; lane < DQ_W; lane++)
    begin : g_lane
      // Pure per-lane xor: no bus inversion is ever applied here
      assign dq_d[lane] = cal_shift_q[0] ^ lane_invert[lane];
    end
  endgenerate

  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      dq_q <= '0;
      dq_oe_q <= 1'b0;
      mask_invert_lane_q <= '0;
      mask_invert_lane_oe_q <= 1'b0;
    end
    else if (clk_en)
    begin
      dq_oe_q <= cal_busy;
      dq_q <= cal_busy ? dq_d : '0;
      // Mask lanes carry the true bit, never inverted
      mask_invert_lane_q <= cal_busy ? {MIL_W{cal_shift_q[0]}} : '0;
      mask_invert_lane_oe_q <= cal_busy && read_bus_inversion_en;
    end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_cal_req;
    mpc_read_cal && !cal_busy;
  endsequence

  sequence s_burst16;
    dq_oe_q [*8] ##1 dq_oe_q [*8] ##1 !dq_oe_q;
  endsequence

  property p_cal_burst;
    @(posedge clock) disable iff (!reset_n || !clk_en)
    s_cal_req |=> ##1 s_burst16;
  endproperty
  a_cal_burst: assert property (p_cal_burst) else $error("calibration burst not 16 beats");

  property p_cal_first_bit;
    @(posedge clock) disable iff (!reset_n || !clk_en)
    s_cal_req |-> ##2 mask_invert_lane_q[0] == $past(cal_a_q[0], 2);
  endproperty
  a_cal_first_bit: assert property (p_cal_first_bit) else $error("first beat not pattern A bit 0");

  property p_cal_b_follows;
    @(posedge clock) disable iff (!reset_n || !clk_en)
    s_cal_req |-> ##10 mask_invert_lane_q[0] == $past(cal_b_q[0], 10);
  endproperty
  a_cal_b_follows: assert property (p_cal_b_follows) else $error("pattern B not after A");

  property p_lane_invert;
    @(posedge clock) disable iff (!reset_n || !clk_en)
    dq_oe_q |-> dq_q[DQ_W-1] == (mask_invert_lane_q[1] ^ $past(upper_invert_register[OP_W-1]))
      && dq_q[0] == (mask_invert_lane_q[0] ^ $past(lower_invert_register[0]));
  endproperty
  a_lane_invert: assert property (p_lane_invert) else $error("lane inversion wrong");

  property p_mask_gate;
    @(posedge clock) disable iff (!reset_n || !clk_en)
    mask_invert_lane_oe_q |-> dq_oe_q && $past(read_bus_inversion_en);
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("mask lanes driven with inversion off");

  property p_trr_write;
    @(posedge clock) disable iff (!reset_n || !clk_en)
    wr_act_trr |=> target_row_refresh_en_q == $past(cmd_bus.mrw_data[TRR_EN_BIT])
      && target_row_refresh_bank_q == $past(cmd_bus.mrw_data[TRR_BANK_LSB +: BANK_W]);
  endproperty
  a_trr_write: assert property (p_trr_write) else $error("row refresh write lost");

  property p_cal_a_write;
    @(posedge clock) disable iff (!reset_n || !clk_en)
    wr_cal_a |=> cal_a_q == $past(cmd_bus.mrw_data);
  endproperty
  a_cal_a_write: assert property (p_cal_a_write) else $error("pattern A write lost");

  property p_cal_b_write;
    @(posedge clock) disable iff (!reset_n || !clk_en)
    wr_cal_b |=> cal_b_q == $past(cmd_bus.mrw_data);
  endproperty
  a_cal_b_write: assert property (p_cal_b_write) else $error("pattern B write lost");

  property p_test_ignored;
    @(posedge clock) disable iff (!reset_n || !clk_en)
    cmd_bus.mrw_stb && cmd_bus.mrw_addr == MA_TEST |=> $stable(runtime_q)
      && $stable(cal_a_q) && $stable(cal_b_q) && $stable(target_row_refresh_en_q);
  endproperty
  a_test_ignored: assert property (p_test_ignored) else $error("test write changed state");

  property p_rsvd_zero;
    @(posedge clock) disable iff (!reset_n || !clk_en)
    cmd_bus.mrr_stb && (cmd_bus.mrr_addr == MA_RSVD_B
      || (cmd_bus.mrr_addr >= MA_RSVD_A_LO && cmd_bus.mrr_addr <= MA_RSVD_A_HI))
      |=> rd_valid_q && rd_data_q == '0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read not zero");

  property p_unused_zero;
    @(posedge clock) disable iff (!reset_n || !clk_en)
    cmd_bus.mrr_stb && cmd_bus.mrr_addr >= MA_UNUSED_LO && cmd_bus.mrr_addr <= MA_UNUSED_HI
      |=> rd_valid_q && rd_data_q == '0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused read not zero");

  property p_act_read;
    @(posedge clock) disable iff (!reset_n || !clk_en)
    cmd_bus.mrr_stb && cmd_bus.mrr_addr == MA_ACT_TRR && activate_unlimited
      |=> rd_data_q[ACT_UNLIM_BIT] && rd_data_q[ACT_CODE_LSB +: ACT_CODE_W] == '0;
  endproperty
  a_act_read: assert property (p_act_read) else $error("unlimited count misreported");

  property p_act_code;
    @(posedge clock) disable iff (!reset_n || !clk_en)
    cmd_bus.mrr_stb && cmd_bus.mrr_addr == MA_ACT_TRR && !activate_unlimited
      |=> !rd_data_q[ACT_UNLIM_BIT] && rd_data_q[ACT_CODE_LSB +: ACT_CODE_W] != ACT_CODE_RSVD;
  endproperty
  a_act_code: assert property (p_act_code) else $error("activate code misreported");

  property p_repair_read;
    @(posedge clock) disable iff (!reset_n || !clk_en)
    cmd_bus.mrr_stb && cmd_bus.mrr_addr == MA_REPAIR
      |=> rd_data_q == OP_W'($past(repair_available));
  endproperty
  a_repair_read: assert property (p_repair_read) else $error("repair flags misread");

  property p_mpc_stop;
    @(posedge clock) disable iff (!reset_n || !clk_en)
    mpc_stop && runtime_q == RST_RUNTIME |=> !strobe_timer_running_q;
  endproperty
  a_mpc_stop: assert property (p_mpc_stop) else $error("stop command ignored");

  property p_runtime_reset;
    @(posedge clock) disable iff (!clk_en)
    $rose(reset_n) |-> runtime_q == RST_RUNTIME && cal_a_q == RST_CAL_A;
  endproperty
  a_runtime_reset: assert property (p_runtime_reset) else $error("bad reset values");
endmodule

// [tb/dmr_ctl_model.sv]
// Controller model issuing mode register and multipurpose commands.
// Assumes the bench calls its tasks; it drives just after falling edges.
`timescale 1ns/1ps
module dmr_ctl_model
  import dmr_pkg::*;
(
  input wire logic clock,
  output logic cs,
  output logic [dmr_pkg::MA_W-1:0] ca
);
  initial
  begin
    cs = 1'b0;
    ca = 6'h00;
  end
  // Idle bus shows the inverse so a stale tick cannot pass for fresh
  task automatic tick2(input logic [5:0] t1, input logic [5:0] t2);
  begin
    @(negedge clock);
    cs = 1'b1;
    ca = t1;
    @(negedge clock);
    cs = 1'b0;
    ca = t2;
    @(negedge clock);
    ca = ~t2;
  end
  endtask
  // Callers keep away from 21h..26h
  task automatic mode_register_write(input logic [5:0] a, input logic [7:0] d);
  begin
    tick2({d[7], CA_MRW1}, a);
    tick2({d[6], CA_MRW2}, d[5:0]);
  end
  endtask
  task automatic mode_register_read(input logic [5:0] a);
  begin
    tick2({1'b0, CA_MRR1}, a);
  end
  endtask
  // Stop is only sent while the run-time setting is zero
  task automatic multipurpose_command(input logic [6:0] op);
  begin
    tick2({op[6], CA_MPC}, op[5:0]);
  end
  endtask
endmodule

// [tb/test_dram_mode_regs_23_to_38.sv]
// Self-checking bench for the mode register bank.
// Assumes the controller model and the design package are compiled first.
`timescale 1ns/1ps
module test_dram_mode_regs_23_to_38
  import dmr_pkg::*;
;
  logic clock, reset_n, clk_en, cs, unlim, rbi, rv, trr_en, run, dq_oe, mil_oe;
  logic [5:0] ca;
  logic [2:0] act, trr_bank;
  logic [7:0] rep, linv, uinv, rdat;
  logic [15:0] dq;
  logic [1:0] mil;
  int bad_count, compares;
  dmr_ctl_model i_ctl (.clock(clock), .cs(cs), .ca(ca));
  dmr_mode_regs i_dut (.clock(clock), .reset_n(reset_n), .clk_en(clk_en), .cs(cs),
    .ca(ca), .activate_limit_code(act), .activate_unlimited(unlim),
    .repair_available(rep), .lower_invert_register(linv), .upper_invert_register(uinv),
    .read_bus_inversion_en(rbi), .rd_valid_q(rv), .rd_data_q(rdat),
    .target_row_refresh_en_q(trr_en), .target_row_refresh_bank_q(trr_bank),
    .strobe_timer_running_q(run), .dq_q(dq), .dq_oe_q(dq_oe),
    .mask_invert_lane_q(mil), .mask_invert_lane_oe_q(mil_oe));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
  begin
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  end
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    int n;
  begin
    n = 0;
    i_ctl.mode_register_read(a);
    while (rv !== 1'b1 && n < 6)
    begin
      @(negedge clock);
      n++;
    end
    chk({15'h0000, rv}, 16'h0001, "read answer");
    chk({8'h00, rdat}, {8'h00, e}, "read data");
  end
  endtask
  task automatic tally_and_finish();
  begin
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    int i;
  begin
    chk({trr_en, 12'h000, trr_bank}, 16'h0000, "refresh reset");
    for (i = 0; i < 8; i++)
    begin
      act = i[2:0];
      rd(MA_ACT_TRR, (i == 7) ? 8'h00 : {5'h00, act});
    end
    unlim = 1'b1;
    act = 3'h3;
    // Bank 6 and flags 1Dh are not mirror images, so bit order shows
    i_ctl.mode_register_write(MA_ACT_TRR, 8'hE0);
    rd(MA_ACT_TRR, 8'h08);
    chk({trr_en, 12'h000, trr_bank}, 16'h8006, "refresh write");
    rd(MA_REPAIR, 8'h1D);
    i_ctl.mode_register_write(MA_RSVD_A_LO, 8'hFF);
    rd(MA_RSVD_A_LO, 8'h00);
    i_ctl.mode_register_write(MA_RSVD_B, 8'hFF);
    rd(MA_RSVD_B, 8'h00);
    i_ctl.mode_register_write(MA_TEST, 8'hFF);
    rd(MA_TEST, 8'h00);
    rd(MA_STROBE_RUNTIME, 8'h00);
    rd(MA_CAL_A, 8'h00);
    $display("test regs done");
  end
  endtask
  task automatic t_timer(input logic [7:0] rt, input int e);
    int n;
  begin
    n = 0;
    i_ctl.mode_register_write(MA_STROBE_RUNTIME, rt);
    i_ctl.multipurpose_command(MPC_OP_START_OSC);
    while (run !== 1'b1 && n < 4)
    begin
      @(negedge clock);
      n++;
    end
    n = 0;
    while (run === 1'b1 && n < 5000)
    begin
      @(negedge clock);
      n++;
    end
    chk(n[15:0], e[15:0], "timer span");
    $display("test timer %0h done", rt);
  end
  endtask
  task automatic t_stop();
  begin
    i_ctl.mode_register_write(MA_STROBE_RUNTIME, 8'h00);
    i_ctl.multipurpose_command(MPC_OP_START_OSC);
    repeat (100) @(negedge clock);
    chk({15'h0000, run}, 16'h0001, "timer free run");
    // Frozen cycles must swallow a whole command
    clk_en = 1'b0;
    i_ctl.multipurpose_command(MPC_OP_STOP_OSC);
    repeat (2) @(negedge clock);
    clk_en = 1'b1;
    chk({15'h0000, run}, 16'h0001, "timer frozen");
    i_ctl.multipurpose_command(MPC_OP_STOP_OSC);
    repeat (2) @(negedge clock);
    chk({15'h0000, run}, 16'h0000, "timer stop");
    $display("test stop done");
  end
  endtask
  task automatic t_cal(input logic rb, input logic [7:0] pa, input logic [7:0] pb);
    logic [15:0] pat;
    logic bt;
    int k;
  begin
    rbi = rb;
    k = 0;
    pat = {pb, pa};
    i_ctl.multipurpose_command(MPC_OP_READ_CAL);
    while (dq_oe !== 1'b1 && k < 6)
    begin
      @(negedge clock);
      k++;
    end
    for (k = 0; k < 16; k++)
    begin
      bt = pat[k];
      chk(dq, {16{bt}} ^ {uinv, linv}, "lane data");
      chk({13'h0000, mil_oe, rb ? mil : 2'b00}, {13'h0000, rb, rb ? {2{bt}} : 2'b00},
        "mask lanes");
      @(negedge clock);
    end
    chk({15'h0000, dq_oe}, 16'h0000, "burst length");
    chk(dq, 16'h0000, "lane idle");
    $display("test calibration done");
  end
  endtask
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Whole run needs about 8000 cycles
  initial
  begin
    #400000;
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    act = 3'h0;
    unlim = 1'b0;
    rep = 8'h1D;
    linv = 8'h0F;
    uinv = 8'h15;
    rbi = 1'b1;
    repeat (3) @(negedge clock);
    reset_n = 1'b1;
    t_regs();
    t_timer(8'h01, 16);
    t_timer(8'h3F, 1008);
    t_timer(8'h7F, 2048);
    t_timer(8'h80, 4096);
    t_stop();
    t_cal(1'b1, RST_CAL_A, RST_CAL_B);
    // Both defaults read the same either way round; 27h and C1h do not
    i_ctl.mode_register_write(MA_CAL_A, 8'h27);
    i_ctl.mode_register_write(MA_CAL_B, 8'hC1);
    t_cal(1'b0, 8'h27, 8'hC1);
    tally_and_finish();
  end
endmodule
